// >>> bench/jbst_jtag_ctl.sv
/*
 * model of the external scan controller: drives the link clock, mode and
 * data lines and reads the device's serial output.
 * assumes the device shifts on rising tck and drives tdo after the fall.
 */
`default_nettype none

module jbst_jtag_ctl (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	timeunit 1ns;
	timeprecision 1ps;

	// link clock stands low outside frames
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// one link clock: lines set while low, tdo read at the rise
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#200 tck = 1'b1;
		q = tdo;
		#200 tck = 1'b0;
	endtask

	// mode pattern lsb first, kept off the system clock edges
	task automatic walk(input logic [7:0] pat, input int n);
		logic q;
		#((63 - ($time % 50)) % 50);
		for (int i = 0; i < n; i++) begin
			step(pat[i], ~tdi, q);
		end
	endtask

	// full scan from idle back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic q;
		walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
		dout = '0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
	endtask
endmodule

`default_nettype wire

// >>> bench/test_jtag_boundary_scan_tap.sv
/*
 * self-checking bench of the scan port: apb registers, scans through the
 * controller model, pin drive and core reset behaviour.
 * assumes jbst_pkg and jbst_defs.svh are compiled first.
 */
`default_nettype none

module test_jtag_boundary_scan_tap;
	import jbst_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [3:0] VER = 4'h2;
	localparam logic [15:0] PART = 16'h5a3c; // arbitrary value
	localparam logic [10:0] MFR = 11'h0a5; // arbitrary value
	localparam logic [31:0] IDW = {VER, PART, MFR, 1'b1};
	// start-up time-out per clock option choice, index 0 rightmost
	localparam logic [3:0][15:0] SUT = {16'h0008, 16'h0030, 16'h0018, 16'h0040};

	typedef struct packed {
		logic [3:0] op;
		logic [5:0] n;
		logic [31:0] din;
		logic [31:0] exp;
	} jbst_row_type;

	// opcode, scan length, data in, data out expected
	jbst_row_type rows [6] = '{
		'{4'h1, 6'd32, 32'h0, IDW},
		'{4'hf, 6'd2, 32'h1, 32'h2},
		'{4'h5, 6'd2, 32'h1, 32'h2},
		'{4'h8, 6'd2, 32'h1, 32'h2},
		'{4'hb, 6'd2, 32'h1, 32'h2},
		'{4'h2, 6'd8, 32'hff, 32'h4e}
	};

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic tap_enable_fuse = 1'b1, debug_enable_fuse = 1'b1;
	logic lock_bit_one = 1'b0, lock_bit_two = 1'b0, ext_reset_n = 1'b1;
	logic [1:0] clk_sel_fuse = 2'b00;
	jbst_pins_type pin_in = 4'ha, core_out = 4'h5, core_oe = 4'h3;
	logic pready, pslverr, tdo, tdo_oe, core_reset, debug_fuse_prog, tck, tms, tdi, e;
	logic [31:0] prdata, q;
	jbst_pins_type pin_out, pin_oe;
	int miscompares = 0, total_checks = 0, cyc = 0, pulses = 0;

	always #25 pclk = ~pclk;

	// cycle ceiling cuts a hang short
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	// counts fuse programming pulses
	always @(posedge pclk) begin
		if (debug_fuse_prog === 1'b1) begin
			pulses <= pulses + 1;
		end
	end

	jbst_tap #(.VERSION(VER), .PART_NUM(PART), .MFR_ID(MFR), .SUT_CYC0(SUT[0]),
		.SUT_CYC1(SUT[1]), .SUT_CYC2(SUT[2]), .SUT_CYC3(SUT[3])) dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe), .tap_enable_fuse(tap_enable_fuse),
		.debug_enable_fuse(debug_enable_fuse), .lock_bit_one(lock_bit_one),
		.lock_bit_two(lock_bit_two), .clk_sel_fuse(clk_sel_fuse),
		.ext_reset_n(ext_reset_n), .core_reset(core_reset),
		.debug_fuse_prog(debug_fuse_prog), .pin_in(pin_in), .core_out(core_out),
		.core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe)
	);

	// a released tdo shows its inverse, so a late or missing enable is caught
	jbst_jtag_ctl ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_oe ? tdo : ~tdo));

	// compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h004, 32'h0, q, e);
		chk("status", {16'h0, q[15:0]}, 32'h0103);
		apb(1'b0, 12'h008, 32'h0, q, e);
		chk("id register", q, IDW);
		apb(1'b0, 12'h010, 32'h0, q, e);
		chk("unmapped", {q[30:0], e}, 32'h1);
		ctl.walk(8'h1f, 6);
		ctl.scan(1'b0, 32, 32'h0, q);
		chk("first scan", q, IDW);
		$display("reset tests done");
		foreach (rows[k]) begin
			ctl.scan(1'b1, 4, {28'h0, rows[k].op}, q);
			chk("ir capture", q, 32'h1);
			ctl.scan(1'b0, int'(rows[k].n), rows[k].din, q);
			chk("dr out", q, rows[k].exp);
			apb(1'b0, 12'h004, 32'h0, q, e);
			chk("ir field", {28'h0, q[11:8]}, {28'h0, rows[k].op});
			$display("row %0d done", k);
		end
		chk("pins free", {24'h0, pin_oe, pin_out}, {24'h0, core_oe, core_out});
		// extest after safe values were preloaded
		ctl.scan(1'b1, 4, 32'h0, q);
		repeat (2) @(posedge pclk);
		chk("extest drive", {24'h0, pin_oe, pin_out}, 32'hff);
		ctl.scan(1'b0, 8, 32'h01, q);
		chk("extest capture", q, 32'hee);
		chk("extest update", {24'h0, pin_oe, pin_out}, 32'h01);
		$display("extest done");
		// core reset bit set, then cleared
		ctl.scan(1'b1, 4, 32'hc, q);
		ctl.scan(1'b0, 1, 32'h1, q);
		chk("core reset on", {30'h0, core_reset, |pin_oe}, 32'h2);
		apb(1'b0, 12'h004, 32'h0, q, e);
		chk("tap kept", {24'h0, q[15:8]}, 32'h1c);
		ctl.scan(1'b0, 1, 32'h0, q);
		chk("reset bit out", q, 32'h1);
		chk("time-out hold", {31'h0, core_reset}, 32'h1);
		repeat (80) @(posedge pclk);
		chk("time-out end", {31'h0, core_reset}, 32'h0);
		// external reset pin under every start-up time-out choice
		for (int k = 0; k < 4; k++) begin
			clk_sel_fuse <= 2'(k);
			ext_reset_n <= 1'b0;
			repeat (4) @(posedge pclk);
			chk("pin reset", {30'h0, core_reset, |pin_oe}, 32'h2);
			ext_reset_n <= 1'b1;
			repeat (SUT[k]) @(posedge pclk);
			chk("pin reset hold", {31'h0, core_reset}, 32'h1);
			repeat (8) @(posedge pclk);
			chk("pin reset end", {31'h0, core_reset}, 32'h0);
		end
		$display("core reset done");
		// five mode-high clocks from shift-dr
		ctl.walk(8'hf9, 8);
		apb(1'b0, 12'h004, 32'h0, q, e);
		chk("tlr state", {24'h0, q[15:8]}, 32'h01);
		// port held off by the control bit, then by the fuse
		apb(1'b1, 12'h000, 32'h1, q, e);
		ctl.walk(8'h02, 4);
		apb(1'b0, 12'h004, 32'h0, q, e);
		chk("bit disabled", {27'h0, q[15:12], q[0]}, 32'h0);
		apb(1'b1, 12'h000, 32'h0, q, e);
		tap_enable_fuse <= 1'b0;
		ctl.walk(8'h02, 4);
		apb(1'b0, 12'h004, 32'h0, q, e);
		chk("fuse disabled", {27'h0, q[15:12], q[0]}, 32'h0);
		tap_enable_fuse <= 1'b1;
		$display("disable done");
		// debug fuse refused while locked, granted after erase
		lock_bit_one <= 1'b1;
		apb(1'b1, 12'h000, 32'h2, q, e);
		apb(1'b0, 12'h004, 32'h0, q, e);
		chk("refused", {27'h0, q[4:3], pulses[2:0]}, 32'h10);
		apb(1'b1, 12'h000, 32'h4, q, e);
		apb(1'b1, 12'h000, 32'h2, q, e);
		apb(1'b0, 12'h004, 32'h0, q, e);
		chk("granted", {27'h0, q[4:3], pulses[2:0]}, 32'h09);
		$display("fuse done");
		// reset in mid-run with bypass loaded: power-up values return
		ctl.scan(1'b1, 4, 32'hf, q);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h004, 32'h0, q, e);
		chk("status after reset", {16'h0, q[15:0]}, 32'h0103);
		ctl.walk(8'h1f, 6);
		ctl.scan(1'b0, 32, 32'h0, q);
		chk("scan after reset", q, IDW);
		$display("mid-run reset done");
		tally_and_finish();
	end
endmodule

`default_nettype wire

// >>> hdl/jbst_defs.svh
/*
 * constants of the boundary-scan test access port: opcodes, id word layout,
 * register offsets, field positions and reset values.
 * assumes inclusion by bare name from the package and the top module.
 */
`ifndef JBST_DEFS_SVH
`define JBST_DEFS_SVH

// chain geometry
`define JBST_NPIN 4
`define JBST_BS_W 8
`define JBST_IR_W 4
`define JBST_ID_W 32
`define JBST_SUT_W 16

// instruction opcodes
`define JBST_OP_EXTEST 4'h0
`define JBST_OP_IDCODE 4'h1
`define JBST_OP_SAMPLE 4'h2
`define JBST_OP_CORE_RST 4'hc
`define JBST_OP_BYPASS 4'hf
`define JBST_IR_CAPTURE 4'h1

// id word field positions
`define JBST_ID_VER_LSB 28
`define JBST_ID_PART_LSB 12
`define JBST_ID_MFR_LSB 1

// register byte offsets
`define JBST_OFS_CTRL 12'h000
`define JBST_OFS_STATUS 12'h004
`define JBST_OFS_IDWORD 12'h008

// control register fields
`define JBST_CTRL_TAP_DIS 0
`define JBST_CTRL_FUSE_PROG 1
`define JBST_CTRL_ERASE 2
`define JBST_CTRL_RST 1'b0

// status register fields
`define JBST_ST_TAP_EN 0
`define JBST_ST_DBG_FUSE 1
`define JBST_ST_CORE_RST 2
`define JBST_ST_ERASED 3
`define JBST_ST_REFUSED 4
`define JBST_ST_IR_LSB 8
`define JBST_ST_TAP_LSB 12

`endif

// >>> hdl/jbst_pkg.sv
/*
 * types of the boundary-scan test access port: controller states, path
 * selection and the packed state record of the top module.
 * assumes jbst_defs.svh is on the include path.
 */
`default_nettype none
`include "jbst_defs.svh"

package jbst_pkg;

	typedef logic [`JBST_NPIN-1:0] jbst_pins_type;
	typedef logic [`JBST_BS_W-1:0] jbst_chain_type;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
		TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
		TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
	} jbst_tap_type;

	typedef enum logic [1:0] {PATH_BYP, PATH_ID, PATH_BS, PATH_RST} jbst_path_type;

	typedef struct packed {
		logic tck_m;
		logic tck_s;
		logic tck_d;
		logic tms_m;
		logic tms_s;
		logic tdi_m;
		logic tdi_s;
		logic rstn_m;
		logic rstn_s;
		jbst_pins_type pin_m;
		jbst_pins_type pin_s;
		logic tap_en;
		jbst_tap_type tap;
		logic [`JBST_IR_W-1:0] ir;
		logic [`JBST_IR_W-1:0] ir_sh;
		logic byp;
		logic [`JBST_ID_W-1:0] id_sh;
		logic rst_reg;
		jbst_chain_type bs_sh;
		jbst_chain_type bs_upd;
		logic [`JBST_SUT_W-1:0] sut_cnt;
		logic core_rst;
		logic tdo;
		logic tdo_oe;
		jbst_pins_type pin_out;
		jbst_pins_type pin_oe;
		logic tap_dis;
		logic erased;
		logic refused;
		logic fuse_prog;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} jbst_state_type;

endpackage

`default_nettype wire

// >>> hdl/jbst_tap.sv
/*
 * boundary-scan test access port with bypass, id, core reset and boundary
 * chain paths, plus an apb slave for control and status.
 * assumes pclk runs well above tck, fuses and lock bits are static,
 * and core_out/core_oe come from logic on pclk.
 */
// The register addresses and the APB slave port were decided locally.
// Behaviour
// - port works only with fuse set, disable clear
// - locked part refuses debug fuse until erased
// - instruction holds idcode after power-up
// - instruction register is four bits wide
// - all shifting goes lsb first
// - bypass is one stage, zero after capture
// - opcode f selects bypass, captures zero
// - id word: version, part, maker fields
// - version follows silicon revision from zero
// - idcode captures and shifts 32-bit id word
// - extest opcode zero drives latched pin values
// - extest captures pins, shifts, updates outputs
// - sample/preload captures, updates latches, pins untouched
// - opcode c selects reset bit, tap unaffected
// - core held in reset while bit is one; here only while opcode c stays loaded
// - start-up time-out follows reset bit release
// - reset from pin or reset instruction
// - pins go high impedance during reset; under extest the pins follow the update latches even in reset
// - no highz instruction exists
// - works without chip clock dependency on tck rate; tck is sampled on pclk, which must run well above tck
// - sixteen-state controller, starts in test-logic-reset
// - five tms-high clocks reach test-logic-reset
// - shift-ir outputs captured value 0001
`default_nettype none
`include "jbst_defs.svh"

module jbst_tap #(
	parameter logic [3:0] VERSION = 4'h0,
	parameter logic [15:0] PART_NUM = 16'h1234, // arbitrary value
	parameter logic [10:0] MFR_ID = 11'h055, // arbitrary value
	parameter logic [15:0] SUT_CYC0 = 16'h0010,
	parameter logic [15:0] SUT_CYC1 = 16'h0040,
	parameter logic [15:0] SUT_CYC2 = 16'h0100,
	parameter logic [15:0] SUT_CYC3 = 16'h1000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic tap_enable_fuse,
	input wire logic debug_enable_fuse,
	input wire logic lock_bit_one,
	input wire logic lock_bit_two,
	input wire logic [1:0] clk_sel_fuse,
	input wire logic ext_reset_n,
	output logic core_reset,
	output logic debug_fuse_prog,
	input wire jbst_pkg::jbst_pins_type pin_in,
	input wire jbst_pkg::jbst_pins_type core_out,
	input wire jbst_pkg::jbst_pins_type core_oe,
	output jbst_pkg::jbst_pins_type pin_out,
	output jbst_pkg::jbst_pins_type pin_oe
);
	import jbst_pkg::*;

	jbst_state_type st;
	jbst_state_type n;
	logic rise;
	logic fall;
	jbst_path_type path;
	logic [`JBST_ID_W-1:0] id_word;
	logic [15:0] sut_sel;
	logic jtag_rst;

	// controller transition on tms
	function automatic jbst_tap_type tap_next(input jbst_tap_type s, input logic m);
		case (s)
			TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAU_DR;
			TAP_PAU_DR: tap_next = m ? TAP_EX2_DR : TAP_PAU_DR;
			TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAU_IR;
			TAP_PAU_IR: tap_next = m ? TAP_EX2_IR : TAP_PAU_IR;
			TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			default: tap_next = TAP_RESET;
		endcase
	endfunction

	// instruction to data path; private and unused codes fall to bypass
	function automatic jbst_path_type path_of(input logic [`JBST_IR_W-1:0] op);
		case (op)
			`JBST_OP_EXTEST: path_of = PATH_BS;
			`JBST_OP_SAMPLE: path_of = PATH_BS;
			`JBST_OP_IDCODE: path_of = PATH_ID;
			`JBST_OP_CORE_RST: path_of = PATH_RST;
			default: path_of = PATH_BYP;
		endcase
	endfunction

	// id word assembly
	assign id_word = {VERSION, PART_NUM, MFR_ID, 1'b1};

	// start-up time-out chosen by clock option fuses
	always_comb begin
		if (clk_sel_fuse == 2'h0) begin
			sut_sel = SUT_CYC0;
		end else if (clk_sel_fuse == 2'h1) begin
			sut_sel = SUT_CYC1;
		end else if (clk_sel_fuse == 2'h2) begin
			sut_sel = SUT_CYC2;
		end else begin
			sut_sel = SUT_CYC3;
		end
	end

	assign rise = st.tck_s & ~st.tck_d; // tck edges seen on pclk
	assign fall = ~st.tck_s & st.tck_d;
	assign path = path_of(st.ir);

	// next state of the whole block
	always_comb begin
		n = st;
		jtag_rst = 1'b0;
		// two-flop synchronisers for pins and the link
		n.tck_m = tck;
		n.tck_s = st.tck_m;
		n.tck_d = st.tck_s;
		n.tms_m = tms;
		n.tms_s = st.tms_m;
		n.tdi_m = tdi;
		n.tdi_s = st.tdi_m;
		n.rstn_m = ext_reset_n;
		n.rstn_s = st.rstn_m;
		n.pin_m = pin_in;
		n.pin_s = st.pin_m;
		n.tap_en = tap_enable_fuse & ~st.tap_dis;

		// tap controller and shift paths
		if (!n.tap_en) begin
			n.tap = TAP_RESET;
			n.ir = `JBST_OP_IDCODE;
			n.rst_reg = 1'b0;
			n.tdo_oe = 1'b0;
		end else if (rise) begin
			case (st.tap)
				TAP_CAP_IR: n.ir_sh = `JBST_IR_CAPTURE;
				TAP_SH_IR: n.ir_sh = {st.tdi_s, st.ir_sh[`JBST_IR_W-1:1]};
				TAP_UPD_IR: n.ir = st.ir_sh;
				TAP_CAP_DR: begin
					case (path)
						PATH_ID: n.id_sh = id_word;
						PATH_BS: begin
							for (int i = 0; i < `JBST_NPIN; i++) begin
								n.bs_sh[2*i] = st.pin_s[i];
								n.bs_sh[2*i+1] = st.pin_oe[i];
							end
						end
						PATH_RST: n.rst_reg = st.rst_reg;
						default: n.byp = 1'b0;
					endcase
				end
				TAP_SH_DR: begin
					case (path)
						PATH_ID: n.id_sh = {st.tdi_s, st.id_sh[`JBST_ID_W-1:1]};
						PATH_BS: n.bs_sh = {st.tdi_s, st.bs_sh[`JBST_BS_W-1:1]};
						PATH_RST: n.rst_reg = st.tdi_s;
						default: n.byp = st.tdi_s;
					endcase
				end
				TAP_UPD_DR: begin
					if (path == PATH_BS) begin
						n.bs_upd = st.bs_sh;
					end
				end
				default: n.byp = st.byp;
			endcase
			n.tap = tap_next(st.tap, st.tms_s);
			n.ir = (n.tap == TAP_RESET) ? `JBST_OP_IDCODE : n.ir; // entering reset
		end else if (fall) begin
			// tdo changes on the falling edge, steady for the next rise
			n.tdo_oe = (st.tap == TAP_SH_IR) || (st.tap == TAP_SH_DR);
			if (st.tap == TAP_SH_IR) begin
				n.tdo = st.ir_sh[0];
			end else begin
				case (path)
					PATH_ID: n.tdo = st.id_sh[0];
					PATH_BS: n.tdo = st.bs_sh[0];
					PATH_RST: n.tdo = st.rst_reg;
					default: n.tdo = st.byp;
				endcase
			end
		end

		// core reset with start-up time-out; reset bit is never latched
		jtag_rst = n.rst_reg & (n.ir == `JBST_OP_CORE_RST);
		if (!st.rstn_s || jtag_rst) begin
			n.sut_cnt = sut_sel;
			n.core_rst = 1'b1;
		end else if (st.sut_cnt != 16'h0000) begin
			n.sut_cnt = st.sut_cnt - 16'h0001;
			n.core_rst = 1'b1;
		end else begin
			n.core_rst = 1'b0;
		end

		// pin drive: extest latches, else core, tri-stated in reset
		for (int i = 0; i < `JBST_NPIN; i++) begin
			if (n.ir == `JBST_OP_EXTEST) begin
				n.pin_out[i] = n.bs_upd[2*i];
				n.pin_oe[i] = n.bs_upd[2*i+1];
			end else begin
				n.pin_out[i] = core_out[i];
				n.pin_oe[i] = core_oe[i] & ~n.core_rst;
			end
		end

		// apb slave: answer prepared in setup, pready in access
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		n.fuse_prog = 1'b0;
		if (psel && !penable) begin
			n.pready = 1'b1;
			n.prdata = 32'h0000_0000;
			if (paddr == `JBST_OFS_CTRL) begin
				n.prdata[`JBST_CTRL_TAP_DIS] = st.tap_dis;
			end else if (paddr == `JBST_OFS_STATUS) begin
				n.prdata[`JBST_ST_TAP_EN] = st.tap_en;
				n.prdata[`JBST_ST_DBG_FUSE] = debug_enable_fuse;
				n.prdata[`JBST_ST_CORE_RST] = st.core_rst;
				n.prdata[`JBST_ST_ERASED] = st.erased;
				n.prdata[`JBST_ST_REFUSED] = st.refused;
				n.prdata[`JBST_ST_IR_LSB+:`JBST_IR_W] = st.ir;
				n.prdata[`JBST_ST_TAP_LSB+:4] = st.tap;
			end else if (paddr == `JBST_OFS_IDWORD) begin
				n.prdata = id_word;
			end else begin
				n.pslverr = 1'b1; // unmapped address
			end
		end else if (psel && penable && !st.pready) begin
			n.pready = 1'b1;
			n.pslverr = st.pslverr;
		end
		// write commit at the completing access edge
		if (psel && penable && st.pready && pwrite && !st.pslverr && pstrb[0]) begin
			if (paddr == `JBST_OFS_CTRL) begin
				n.tap_dis = pwdata[`JBST_CTRL_TAP_DIS];
				if (pwdata[`JBST_CTRL_ERASE]) begin
					n.erased = 1'b1;
					n.refused = 1'b0;
				end
				if (pwdata[`JBST_CTRL_FUSE_PROG]) begin
					if ((lock_bit_one || lock_bit_two) && !n.erased) begin
						n.refused = 1'b1;
					end else begin
						n.fuse_prog = 1'b1;
					end
				end
			end
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.tap <= TAP_RESET;
			st.ir <= `JBST_OP_IDCODE;
			st.rstn_m <= 1'b1;
			st.rstn_s <= 1'b1;
			st.tap_dis <= `JBST_CTRL_RST;
		end else begin
			st <= n;
		end
	end

	assign pready = st.pready;
	assign prdata = st.prdata;
	assign pslverr = st.pslverr;
	assign tdo = st.tdo;
	assign tdo_oe = st.tdo_oe;
	assign core_reset = st.core_rst;
	assign debug_fuse_prog = st.fuse_prog;
	assign pin_out = st.pin_out;
	assign pin_oe = st.pin_oe;

	// helper: consecutive tms-high rises, saturating at five
	logic [2:0] tms_hi_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tms_hi_cnt <= 3'h0;
		end else if (rise) begin
			tms_hi_cnt <= !st.tms_s ? 3'h0 : (tms_hi_cnt == 3'h5) ? 3'h5 : tms_hi_cnt + 3'h1;
		end
	end

	a_tlr_five_ones: assert property (@(posedge pclk) disable iff (!presetn)
		(tms_hi_cnt == 3'h5) |-> (st.tap == TAP_RESET))
		else $error("five tms-high clocks did not reach test-logic-reset");

	a_tap_disabled: assert property (@(posedge pclk) disable iff (!presetn)
		!st.tap_en |-> (st.tap == TAP_RESET) && !st.tdo_oe)
		else $error("disabled port left test-logic-reset");

	a_ir_default: assert property (@(posedge pclk) disable iff (!presetn)
		(st.tap == TAP_RESET) && $past(st.tap == TAP_RESET) |-> (st.ir == `JBST_OP_IDCODE))
		else $error("instruction not idcode in test-logic-reset");

	a_ir_capture: assert property (@(posedge pclk) disable iff (!presetn)
		rise && st.tap_en && (st.tap == TAP_CAP_IR) |=> (st.ir_sh == 4'h1))
		else $error("capture-ir did not load 0001");

	a_ir_lsb_first: assert property (@(posedge pclk) disable iff (!presetn)
		rise && st.tap_en && (st.tap == TAP_SH_IR)
		|=> (st.ir_sh[3] == $past(st.tdi_s)) && (st.ir_sh[2:0] == $past(st.ir_sh[3:1])))
		else $error("instruction shift not lsb first");

	a_bypass_zero: assert property (@(posedge pclk) disable iff (!presetn)
		rise && st.tap_en && (st.tap == TAP_CAP_DR) && (path == PATH_BYP) |=> !st.byp)
		else $error("bypass not zero after capture");

	a_id_capture: assert property (@(posedge pclk) disable iff (!presetn)
		rise && st.tap_en && (st.tap == TAP_CAP_DR) && (st.ir == 4'h1)
		|=> (st.id_sh == {VERSION, PART_NUM, MFR_ID, 1'b1}))
		else $error("id word not captured");

	a_reset_follows: assert property (@(posedge pclk) disable iff (!presetn)
		st.rst_reg && (st.ir == 4'hc) |-> core_reset)
		else $error("core not in reset while reset bit set");

	a_reset_timeout: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(st.rst_reg & (st.ir == 4'hc)) && (sut_sel > 16'h0002) |-> core_reset [*2])
		else $error("start-up time-out not applied");

	a_extest_drive: assert property (@(posedge pclk) disable iff (!presetn)
		(st.ir == 4'h0) |-> (pin_oe[0] == st.bs_upd[1]) && (pin_out[0] == st.bs_upd[0]))
		else $error("extest latches not driving pins");

	a_reset_hiz: assert property (@(posedge pclk) disable iff (!presetn)
		core_reset && (st.ir != 4'h0) |-> (pin_oe == '0))
		else $error("pins driven during reset");

	a_fuse_refused: assert property (@(posedge pclk) disable iff (!presetn)
		(lock_bit_one || lock_bit_two) && !st.erased && !$rose(st.erased) |-> !debug_fuse_prog)
		else $error("debug fuse programmed on locked part");

endmodule

`default_nettype wire
